// ### logic/srs_consts.svh
// register indices, field positions, reset values and counts of the rate and shift block
`ifndef SRS_CONSTS_SVH
`define SRS_CONSTS_SVH

`define SRS_IDX_DATA      8'hC2
`define SRS_IDX_RATE      8'hC5
`define SRS_IDX_CTRL      8'hC6

`define SRS_RST_DATA      8'h00
`define SRS_RST_RATE      8'h00

`define SRS_BIT_ENABLE    0
`define SRS_BIT_FREE_EN   1
`define SRS_BIT_START     2
`define SRS_BIT_EVENT     3
`define SRS_BIT_LOST      4
`define SRS_BIT_TX        5
`define SRS_BIT_FREE      6

`define SRS_CNT_LAST      8'hFF
`define SRS_LOW_BASE      9'h100
`define SRS_FREE_MULT     12'h00A
`define SRS_FREE_BASE     12'h101
`define SRS_BITS_PER_BYTE 4'h8

`endif

// ### logic/srs_pkg.sv
// types shared by the rate and shift block
package srs_pkg;

  typedef enum logic [3:0] {
    SRS_IDLE  = 4'h1,
    SRS_START = 4'h2,
    SRS_SHIFT = 4'h4,
    SRS_HOLD  = 4'h8
  } srs_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } srs_lines_t;

  typedef struct packed {
    logic freeSeen;
    logic masterTx;
    logic lostArb;
    logic serialEvent;
    logic startPend;
    logic busFreeTimerEn;
    logic serialIfEnable;
  } srs_ctrl_t;

endpackage

// ### logic/srs_sync2.sv
// two-flop synchroniser for level signals
`timescale 1ns/100ps
`default_nettype none

module srs_sync2 #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  // data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      // reset value matches the idle level of what is sampled, so no false edge follows
      meta_reg <= RST_VAL;
      dout     <= RST_VAL;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end

endmodule

`default_nettype wire

// ### logic/srs_scl_rate_shift.sv
// clock rate generator and data shift register of the two-wire serial interface
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "srs_consts.svh"

// How it works
// R1: rate byte preloads an 8-bit up-counter; each wrap toggles the clock line and reloads.
// R2: clock low time is 256 minus the rate value system clock periods.
// R3: clock high time is 256 minus rate periods plus the delay of the clock line synchronisers.
// R4: the eight-bit holding register keeps the byte to send or the byte received.
// R5: while the serial event flag is set, the holding register does not shift.
// R6: software may read or write the holding register while the event flag is set.
// R7: software leaves the holding register alone while enabled and the event flag clear.
// R8: bytes leave the device most significant bit first.
// R9: the first bit sampled from the bus ends in the most significant position.
// R10: bus data shifts in while shifting out, so the last bus byte is kept.
// R11: after lost arbitration the holding register already holds the received bus data.
// R12: with free timer enabled, both lines high for the timeout frees the bus.
// R13: software picks a rate value that keeps clock times within bus limits.
module srs_scl_rate_shift
  import srs_pkg::*;
(
  // system clock and reset
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  // link sampling clock
  input  wire logic        linkClk,
  // register bus
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // serial clock line
  input  wire logic        sclIn,
  output logic             sclOut,
  output logic             sclOe,
  // serial data line
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe
);

  srs_lines_t linkLines;
  srs_lines_t linkPrev_reg;
  logic       bitVal_reg;
  logic       bitTgl_reg;
  srs_lines_t sysLines;
  logic       sysTgl;
  logic       tglPrev_reg;
  logic       bitEvent;

  logic [7:0]  rate_reg;
  logic [7:0]  shift_reg;
  srs_ctrl_t   ctrl_reg;
  srs_ctrl_t   ctrl_next;
  srs_state_t  state_reg;
  logic [7:0]  cnt_reg;
  logic        sclLevel_reg;
  logic        sdaDrive_reg;
  logic [3:0]  bitCnt_reg;
  logic [11:0] freeCnt_reg;
  logic [11:0] freeLimit;
  logic        ack_reg;
  logic [7:0]  idx;
  logic        wrEn;
  logic        running;
  logic        inc;
  logic        wrap;
  logic        byteDone;
  logic        fallTick;
  logic        startGo;
  logic        holdSet;
  logic        lostSet;
  logic        resume;

  // link side: pins sampled on the link clock, rising clock edges carry one data bit
  srs_sync2 #(.W(2), .RST_VAL(2'h3)) uPinSync (
    .clk    (linkClk),
    .arst_n (arst_n),
    .din    ({sclIn, sdaIn}),
    .dout   (linkLines)
  );

  always_ff @(posedge linkClk or negedge arst_n) begin
    if (!arst_n) begin
      linkPrev_reg <= '1;
      bitVal_reg   <= 1'b1;
      bitTgl_reg   <= 1'b0;
    end else begin
      linkPrev_reg <= linkLines;
      if (linkLines.scl && !linkPrev_reg.scl) begin
        bitVal_reg <= linkLines.sda;
        bitTgl_reg <= ~bitTgl_reg;
      end
    end
  end

  // bit value is held until the next toggle, so it is stable when the toggle arrives
  srs_sync2 #(.W(3), .RST_VAL(3'h6)) uSysSync (
    .clk    (sys_clk),
    .arst_n (arst_n),
    .din    ({linkPrev_reg, bitTgl_reg}),
    .dout   ({sysLines, sysTgl})
  );

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tglPrev_reg <= 1'b0;
    end else begin
      tglPrev_reg <= sysTgl;
    end
  end

  assign bitEvent = sysTgl ^ tglPrev_reg;

  // register bus: one wait state, write and read data at the edge with waitrequest low
  assign idx             = avs_address[9:2];
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  assign wrEn            = avs_write && ack_reg;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read || avs_write) && !ack_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_reg) begin
      case (idx)
        `SRS_IDX_DATA: avs_readdata <= {24'h00_0000, shift_reg};
        `SRS_IDX_RATE: avs_readdata <= {24'h00_0000, rate_reg};
        `SRS_IDX_CTRL: avs_readdata <= {25'h000_0000, ctrl_reg};
        default:       avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rate_reg <= `SRS_RST_RATE;
    end else if (wrEn && idx == `SRS_IDX_RATE) begin
      rate_reg <= avs_writedata[7:0];
    end
  end

  // rate counter: runs from the rate value up, wraps toggle the clock line
  assign running  = (state_reg == SRS_START) || (state_reg == SRS_SHIFT);
  assign inc      = running && (!sclLevel_reg || sysLines.scl);
  assign wrap     = inc && (cnt_reg == `SRS_CNT_LAST);
  assign byteDone = (bitCnt_reg == `SRS_BITS_PER_BYTE);
  assign fallTick = wrap && sclLevel_reg && (state_reg == SRS_SHIFT);
  assign startGo  = (state_reg == SRS_IDLE) && ctrl_reg.serialIfEnable && ctrl_reg.startPend
                    && ctrl_reg.freeSeen && !ctrl_reg.serialEvent; // R5
  assign holdSet  = fallTick && byteDone;
  assign resume   = (state_reg == SRS_HOLD) && ctrl_reg.serialIfEnable && !ctrl_reg.serialEvent;
  assign lostSet  = bitEvent && (state_reg == SRS_SHIFT) && ctrl_reg.masterTx
                    && !ctrl_reg.lostArb && shift_reg[7] && !bitVal_reg;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= `SRS_RST_RATE;
    end else if (!running || wrap) begin
      cnt_reg <= rate_reg; // R1
    end else if (inc) begin
      cnt_reg <= cnt_reg + 8'h01; // R2 R3
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclLevel_reg <= 1'b1;
    end else begin
      case (state_reg)
        SRS_IDLE:  sclLevel_reg <= 1'b1;
        SRS_START: sclLevel_reg <= wrap ? 1'b0 : 1'b1;
        SRS_SHIFT: sclLevel_reg <= wrap ? ~sclLevel_reg : sclLevel_reg; // R1
        SRS_HOLD:  sclLevel_reg <= 1'b0;
        default:   sclLevel_reg <= 1'b1;
      endcase
    end
  end

  // sequencer
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= SRS_IDLE;
    end else if (!ctrl_reg.serialIfEnable) begin
      state_reg <= SRS_IDLE;
    end else begin
      case (state_reg)
        SRS_IDLE:  state_reg <= startGo ? SRS_START : SRS_IDLE; // R12
        SRS_START: state_reg <= wrap ? SRS_SHIFT : SRS_START;
        SRS_SHIFT: state_reg <= holdSet ? SRS_HOLD : SRS_SHIFT;
        SRS_HOLD:  state_reg <= resume ? SRS_SHIFT : SRS_HOLD; // R5
        default:   state_reg <= SRS_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bitCnt_reg <= 4'h0;
    end else if (state_reg != SRS_SHIFT) begin
      bitCnt_reg <= 4'h0;
    end else if (bitEvent && !byteDone) begin
      bitCnt_reg <= bitCnt_reg + 4'h1;
    end
  end

  // data line drive: start holds it low, each falling clock edge before the byte ends presents the next top bit, the last one releases it
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sdaDrive_reg <= 1'b0;
    end else if (!ctrl_reg.serialIfEnable || lostSet
                 || (ctrl_reg.lostArb && (state_reg == SRS_SHIFT || state_reg == SRS_HOLD))) begin
      sdaDrive_reg <= 1'b0; // R11
    end else if (startGo) begin
      sdaDrive_reg <= 1'b1;
    end else if ((state_reg == SRS_START && wrap) || resume) begin
      sdaDrive_reg <= ctrl_reg.masterTx && !shift_reg[7]; // R8
    end else if (fallTick) begin
      sdaDrive_reg <= !byteDone && ctrl_reg.masterTx && !shift_reg[7]; // R8
    end
  end

  // holding register: software writes outside the start and shift states, bus bits shift in at the bottom
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_reg <= `SRS_RST_DATA;
    end else if (state_reg == SRS_SHIFT) begin
      if (bitEvent && !byteDone) begin
        shift_reg <= {shift_reg[6:0], bitVal_reg}; // R9 R10 R11
      end
    end else if (wrEn && idx == `SRS_IDX_DATA && state_reg != SRS_START) begin
      shift_reg <= avs_writedata[7:0]; // R4 R6
    end
  end

  // bus free timer: both lines high for ten times (256 - rate + 1) cycles
  assign freeLimit = 12'(`SRS_FREE_MULT * (`SRS_FREE_BASE - {4'h0, rate_reg}));

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      freeCnt_reg <= 12'h000;
    end else if (!ctrl_reg.busFreeTimerEn || !sysLines.scl || !sysLines.sda) begin
      freeCnt_reg <= 12'h000;
    end else if (freeCnt_reg != freeLimit) begin
      freeCnt_reg <= freeCnt_reg + 12'h001; // R12
    end
  end

  // control flags: hardware set wins over a software clear in the same cycle
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wrEn && idx == `SRS_IDX_CTRL) begin
      ctrl_next.serialIfEnable = avs_writedata[`SRS_BIT_ENABLE];
      ctrl_next.busFreeTimerEn = avs_writedata[`SRS_BIT_FREE_EN];
      ctrl_next.masterTx       = avs_writedata[`SRS_BIT_TX];
      if (avs_writedata[`SRS_BIT_START]) begin
        ctrl_next.startPend = 1'b1;
      end
      if (!avs_writedata[`SRS_BIT_EVENT]) begin
        ctrl_next.serialEvent = 1'b0;
      end
      if (!avs_writedata[`SRS_BIT_LOST]) begin
        ctrl_next.lostArb = 1'b0;
      end
    end
    if (startGo && !(wrEn && idx == `SRS_IDX_CTRL && avs_writedata[`SRS_BIT_START])) begin
      ctrl_next.startPend = 1'b0;
    end
    if (holdSet) begin
      ctrl_next.serialEvent = 1'b1; // R5
    end
    if (lostSet) begin
      ctrl_next.lostArb  = 1'b1; // R11
      ctrl_next.masterTx = 1'b0;
    end
    ctrl_next.freeSeen = ctrl_reg.busFreeTimerEn && sysLines.scl && sysLines.sda
                         && (freeCnt_reg == freeLimit); // R12
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= '0;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // open-drain pins: enable high pulls the line low
  assign sclOut = 1'b0;
  assign sclOe  = !sclLevel_reg;
  assign sdaOut = 1'b0;
  assign sdaOe  = sdaDrive_reg;

  // phase length measurement for the checks below
  logic [8:0] lowLen_reg;
  logic [8:0] highLen_reg;
  logic [8:0] lowExpect;

  assign lowExpect = `SRS_LOW_BASE - {1'b0, rate_reg};

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      lowLen_reg  <= 9'h000;
      highLen_reg <= 9'h000;
    end else begin
      // time held low in the hold state is not part of a generated low phase
      lowLen_reg  <= (sclLevel_reg || state_reg != SRS_SHIFT) ? 9'h000 : lowLen_reg + 9'h001;
      highLen_reg <= sclLevel_reg ? highLen_reg + 9'h001 : 9'h000;
    end
  end

  property p_R1;
    @(posedge sys_clk) disable iff (!arst_n)
      (state_reg == SRS_SHIFT && wrap) |=>
        (sclLevel_reg != $past(sclLevel_reg)) && (cnt_reg == $past(rate_reg));
  endproperty
  a_R1: assert property (p_R1) else $error("clock line did not toggle on counter wrap"); // R1

  property p_R2;
    @(posedge sys_clk) disable iff (!arst_n)
      ($rose(sclLevel_reg) && $past(state_reg) == SRS_SHIFT && $stable(rate_reg))
        |-> ($past(lowLen_reg) + 9'h001 == lowExpect);
  endproperty
  a_R2: assert property (p_R2) else $error("clock low time differs from 256 minus rate"); // R2

  property p_R3;
    @(posedge sys_clk) disable iff (!arst_n)
      ($fell(sclLevel_reg) && $past(state_reg) == SRS_SHIFT)
        |-> ($past(highLen_reg) + 9'h001 >= lowExpect + 9'h002);
  endproperty
  a_R3: assert property (p_R3) else $error("clock high time shorter than expected"); // R3

  property p_R4;
    @(posedge sys_clk) disable iff (!arst_n)
      (avs_read && !ack_reg && idx == `SRS_IDX_DATA)
        |=> (avs_readdata[7:0] == $past(shift_reg)) && (avs_readdata[31:8] == 24'h00_0000);
  endproperty
  a_R4: assert property (p_R4) else $error("holding register read back wrong"); // R4

  property p_R5;
    @(posedge sys_clk) disable iff (!arst_n)
      (ctrl_reg.serialEvent && !(wrEn && idx == `SRS_IDX_DATA)) |=> $stable(shift_reg);
  endproperty
  a_R5: assert property (p_R5) else $error("holding register changed while event flag set"); // R5

  property p_R8;
    @(posedge sys_clk) disable iff (!arst_n)
      (fallTick && !byteDone && ctrl_reg.masterTx && !lostSet && ctrl_reg.serialIfEnable)
        |=> (sdaOe == !$past(shift_reg[7])) && !sclOe == 1'b0;
  endproperty
  a_R8: assert property (p_R8) else $error("data line does not carry the top bit"); // R8

  property p_R9;
    @(posedge sys_clk) disable iff (!arst_n)
      (bitEvent && state_reg == SRS_SHIFT && !byteDone)
        |=> (shift_reg == {$past(shift_reg[6:0]), $past(bitVal_reg)});
  endproperty
  a_R9: assert property (p_R9) else $error("sampled bit not shifted in at the bottom"); // R9 R10

  property p_R11;
    @(posedge sys_clk) disable iff (!arst_n)
      lostSet |=> ctrl_reg.lostArb && !sdaOe ##1 !sdaOe;
  endproperty
  a_R11: assert property (p_R11) else $error("lost arbitration did not release the data line"); // R11

  property p_R12;
    @(posedge sys_clk) disable iff (!arst_n)
      (state_reg == SRS_IDLE && ctrl_reg.serialIfEnable && ctrl_reg.startPend
        && ctrl_reg.freeSeen && !ctrl_reg.serialEvent) |=> (state_reg == SRS_START) && sdaOe;
  endproperty
  a_R12: assert property (p_R12) else $error("pending start not issued on a free bus"); // R12

endmodule

`default_nettype wire

// ### bench/srs_bus_partner.sv
// far-side bus party: places a byte on the data line and records every clocked bit
`timescale 1ns/100ps
`default_nettype none

module srs_bus_partner (
  // reset
  input  wire logic       arst_n,
  // resolved bus wires
  input  wire logic       scl,
  input  wire logic       sda,
  // byte to drive, armed while the clock line is held low
  input  wire logic       arm,
  input  wire logic [7:0] txByte,
  // pull-down request and captured bus byte
  output logic            sdaPull,
  output logic [7:0]      seenByte
);
  logic [3:0] leftBits;

  // first sampled bit ends at the top after eight clocks
  always @(posedge scl or negedge arst_n) begin
    if (!arst_n) begin
      seenByte <= 8'h00;
    end else begin
      seenByte <= {seenByte[6:0], sda};
    end
  end

  // data changes only while the clock is low; released line floats to the pull-up
  always @(negedge scl or posedge arm or negedge arst_n) begin
    if (!arst_n) begin
      leftBits <= 4'h0;
      sdaPull  <= 1'b0;
    end else if (arm) begin
      leftBits <= 4'h8;
      sdaPull  <= ~txByte[7];
    end else if (leftBits > 4'h1) begin
      leftBits <= leftBits - 4'h1;
      sdaPull  <= ~txByte[leftBits - 4'h2];
    end else begin
      leftBits <= 4'h0;
      sdaPull  <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// ### bench/testbench.sv
// self-checking bench of the rate generator and shift register
`timescale 1ns/100ps
`default_nettype none
`include "srs_consts.svh"

`define CHK(nm, e, g) begin checksDone++; if ((e) !== (g)) begin failCount++; \
  $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end

module testbench;
  import srs_pkg::*;

  logic        sys_clk;
  logic        arst_n;
  logic        linkClk;
  logic [9:0]  avsAddress;
  logic        avsRead;
  logic        avsWrite;
  logic [31:0] avsWritedata;
  logic [31:0] avsReaddata;
  logic        avsWaitrequest;
  logic        sclOe;
  logic        sdaOe;
  logic        sdaPull;
  logic        sclOutPin;
  logic        sdaOutPin;
  logic        arm;
  logic [7:0]  pTx;
  logic [7:0]  seenByte;
  logic [7:0]  rate;
  logic [7:0]  txB;
  logic [7:0]  rxB;
  logic [7:0]  rd;
  logic [7:0]  expB;
  srs_lines_t  busLines;
  int          failCount;
  int          checksDone;
  int          seed;
  int          lowCnt;
  int          highCnt;
  int          lastLow;
  int          lastHigh;

  // open-drain wires: an enabled driver puts its output level on the line, else the pull-up
  assign busLines.scl = sclOe ? sclOutPin : 1'b1;
  assign busLines.sda = (sdaOe ? sdaOutPin : 1'b1) & ~sdaPull;

  srs_scl_rate_shift i_srs_scl_rate_shift (
    .sys_clk(sys_clk), .arst_n(arst_n), .linkClk(linkClk),
    .avs_address(avsAddress), .avs_read(avsRead), .avs_write(avsWrite),
    .avs_writedata(avsWritedata), .avs_readdata(avsReaddata),
    .avs_waitrequest(avsWaitrequest),
    .sclIn(busLines.scl), .sclOut(sclOutPin), .sclOe(sclOe),
    .sdaIn(busLines.sda), .sdaOut(sdaOutPin), .sdaOe(sdaOe)
  );

  srs_bus_partner i_srs_bus_partner (
    .arst_n(arst_n), .scl(busLines.scl), .sda(busLines.sda), .arm(arm),
    .txByte(pTx), .sdaPull(sdaPull), .seenByte(seenByte)
  );

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  initial begin
    linkClk = 1'b0;
    #7;
    forever #32 linkClk = ~linkClk;
  end

  // length of the last completed low and high phase of the clock line
  always @(posedge sys_clk) begin
    lowCnt  <= sclOe ? lowCnt + 1 : 0;
    highCnt <= sclOe ? 0 : highCnt + 1;
    if (!sclOe && lowCnt != 0) lastLow <= lowCnt;
    if (sclOe && highCnt != 0) lastHigh <= highCnt;
  end

  task automatic busWr(input logic [7:0] idx, input logic [7:0] d);
    avsAddress   <= {idx, 2'b00};
    avsWritedata <= {24'h000000, d};
    avsWrite     <= 1'b1;
    @(posedge sys_clk);
    while (avsWaitrequest !== 1'b0) @(posedge sys_clk);
    avsWrite <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic busRd(input logic [7:0] idx, output logic [7:0] d);
    avsAddress <= {idx, 2'b00};
    avsRead    <= 1'b1;
    @(posedge sys_clk);
    while (avsWaitrequest !== 1'b0) @(posedge sys_clk);
    d = avsReaddata[7:0];
    avsRead <= 1'b0;
    @(posedge sys_clk);
  endtask

  // polls only the control register, never the holding register, while a byte moves
  task automatic waitEvent;
    logic [7:0] c;
    int         n;
    c = 8'h00;
    n = 0;
    while (c[`SRS_BIT_EVENT] !== 1'b1 && n < 3000) begin
      busRd(`SRS_IDX_CTRL, c);
      n++;
    end
    `CHK("event flag", 1'b1, c[`SRS_BIT_EVENT])
  endtask

  // wired-AND bus model, msb first: a transmitter that sees its released 1 low stops driving
  function automatic logic [7:0] busByte(input logic [7:0] dev, input logic [7:0] part,
                                         input logic tx);
    logic       q[$];
    logic       drive;
    logic       b;
    logic [7:0] r;
    drive = tx;
    r     = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      b = (drive ? dev[i] : 1'b1) & part[i];
      if (drive && dev[i] && !b) drive = 1'b0;
      q.push_back(b);
    end
    while (q.size() > 0) r = {r[6:0], q.pop_front()};
    return r;
  endfunction

  task automatic armPartner(input logic [7:0] b);
    pTx <= b;
    @(posedge sys_clk);
    arm <= 1'b1;
    @(posedge sys_clk);
    arm <= 1'b0;
  endtask

  task automatic summarize;
    if (failCount == 0 && checksDone > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // whole run needs some 2000 cycles; allow 20000
  initial begin
    #400000;
    failCount++;
    summarize();
  end

  initial begin
    seed = 32'h2E87;
    failCount = 0;
    checksDone = 0;
    arst_n = 1'b0;
    avsAddress = 10'h000;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsWritedata = 32'h00000000;
    arm = 1'b0;
    pTx = 8'h00;
    repeat (4) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    busRd(`SRS_IDX_DATA, rd);
    `CHK("data reset", `SRS_RST_DATA, rd)
    busRd(`SRS_IDX_RATE, rd);
    `CHK("rate reset", `SRS_RST_RATE, rd)
    busWr(8'h00, 8'h5A);
    busRd(8'h00, rd);
    `CHK("unmapped", 8'h00, rd)
    rate = 8'hF0 | (8'($random(seed)) & 8'h07);
    busWr(`SRS_IDX_RATE, rate);
    busRd(`SRS_IDX_RATE, rd);
    `CHK("rate rw", rate, rd)
    txB = 8'($random(seed));
    busWr(`SRS_IDX_DATA, txB);
    busRd(`SRS_IDX_DATA, rd);
    `CHK("data rw", txB, rd)
    busWr(`SRS_IDX_CTRL, 8'h25);
    repeat (600) @(posedge sys_clk);
    `CHK("no start timer off", 1'b0, sdaOe | sclOe)
    busRd(`SRS_IDX_CTRL, rd);
    `CHK("start still pending", 1'b1, rd[`SRS_BIT_START])
    `CHK("bus free seen off", 1'b0, rd[`SRS_BIT_FREE])
    busWr(`SRS_IDX_CTRL, 8'h27);
    waitEvent();
    expB = busByte(txB, 8'hFF, 1'b1);
    `CHK("bus byte tx", expB, seenByte)
    busRd(`SRS_IDX_DATA, rd);
    `CHK("data after tx", expB, rd)
    `CHK("low phase", 256 - int'(rate), lastLow)
    `CHK("high phase", 1'b1, lastHigh >= 257 - int'(rate) && lastHigh <= 296 - int'(rate))
    repeat (200) @(posedge sys_clk);
    busRd(`SRS_IDX_DATA, rd);
    `CHK("data stable", txB, rd)
    busWr(`SRS_IDX_DATA, ~txB);
    busRd(`SRS_IDX_DATA, rd);
    `CHK("data write in hold", ~txB, rd)
    rxB = 8'($random(seed));
    armPartner(rxB);
    busWr(`SRS_IDX_CTRL, 8'h03);
    waitEvent();
    busRd(`SRS_IDX_DATA, rd);
    expB = busByte(8'hFF, rxB, 1'b0);
    `CHK("data rx", expB, rd)
    `CHK("bus byte rx", expB, seenByte)
    txB = 8'($random(seed)) | 8'h80;
    rxB = rxB & 8'h7F;
    busWr(`SRS_IDX_DATA, txB);
    armPartner(rxB);
    busWr(`SRS_IDX_CTRL, 8'h23);
    waitEvent();
    busRd(`SRS_IDX_DATA, rd);
    expB = busByte(txB, rxB, 1'b1);
    `CHK("data after loss", expB, rd)
    `CHK("bus byte loss", expB, seenByte)
    busRd(`SRS_IDX_CTRL, rd);
    `CHK("lost flag", 1'b1, rd[`SRS_BIT_LOST])
    `CHK("tx cleared", 1'b0, rd[`SRS_BIT_TX])
    summarize();
  end
endmodule

`default_nettype wire
